//--- design/cbim_pkg.sv
// Constants for the charger and boost event mask and identification block.
// Assumes a serial two-wire register bus clocked by the device core clock.
package cbim_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CBIM_CHG_STATUS_OFS = 8'h09;
  localparam logic [7:0] CBIM_BST_STATUS_OFS = 8'h0a;
  localparam logic [7:0] CBIM_CHG_MASK_OFS = 8'h0c;
  localparam logic [7:0] CBIM_BST_MASK_OFS = 8'h0d;
  localparam logic [7:0] CBIM_ID_OFS = 8'h0e;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CBIM_MASK_RESET = 8'h00;
  localparam logic [7:0] CBIM_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] CBIM_BST_EVENT_BITS = 8'hf8;
  localparam int CBIM_ID_MAKER_POS = 6;
  localparam int CBIM_ID_PART_POS = 3;
  localparam int CBIM_ID_VERSION_POS = 0;

  // ----------------------------------------------------------------
  // Serial bus framing
  // ----------------------------------------------------------------
  localparam logic [3:0] CBIM_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CBIM_BIT_CNT_RESET = 4'h0;

  typedef enum logic [3:0] {
    CBIM_IDLE,
    CBIM_ADDR,
    CBIM_ADDR_ACK,
    CBIM_PTR,
    CBIM_PTR_ACK,
    CBIM_WDATA,
    CBIM_WDATA_ACK,
    CBIM_RDATA,
    CBIM_RDATA_ACK
  } cbim_state_type;

endpackage : cbim_pkg

//--- design/cbim_sync.sv
// Two-stage synchroniser for asynchronous pin and analog status levels.
// Assumes inputs are levels from outside the core clock domain.
`timescale 1ns/10ps
module cbim_sync
  import cbim_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // ----------------------------------------------------------------
  // Two flip-flop chain
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : cbim_sync

//--- design/cbim_top.sv
// Event mask registers, identification and interrupt request behind a
// two-wire serial register bus.
// Assumes open-drain bus pins and status levels held by outside logic.
`timescale 1ns/10ps
module cbim_top
  import cbim_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = 7'h3a,
  parameter logic [1:0] ID_MAKER = 2'h2,    // Arbitrary value
  parameter logic [2:0] ID_PART = 3'h5,     // Arbitrary value
  parameter logic [2:0] ID_VERSION = 3'h6   // Arbitrary value
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [7:0] charger_event_status_in,
  input wire logic [7:0] boost_event_status_in,
  output logic int_req_out
);

  logic [17:0] sync_bus;
  logic scl_s;
  logic sda_s;
  logic [7:0] chg_status;
  logic [7:0] bst_status;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  cbim_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic nack_reg;
  logic sda_oe_reg;
  logic sda_out_reg;
  logic [7:0] charger_event_mask_reg;
  logic [7:0] boost_event_mask_reg;
  logic int_req_reg;
  logic int_req_next;
  logic [7:0] id_value;
  logic [7:0] rd_value;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  cbim_sync #(
    .WIDTH(18)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({~scl_in, ~sda_in, charger_event_status_in, boost_event_status_in}),
    .sync_out(sync_bus)
  );

  assign scl_s = ~sync_bus[17];
  assign sda_s = ~sync_bus[16];
  assign chg_status = sync_bus[15:8];
  assign bst_status = sync_bus[7:0];

  assign id_value = {ID_MAKER, ID_PART, ID_VERSION};

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0] ofs, input logic [7:0] chg_st,
                                          input logic [7:0] bst_st, input logic [7:0] chg_mk,
                                          input logic [7:0] bst_mk, input logic [7:0] ident);
    logic [7:0] val;
    val = CBIM_UNMAPPED_READ;
    if (ofs == CBIM_CHG_STATUS_OFS)
      val = chg_st;
    else if (ofs == CBIM_BST_STATUS_OFS)
      val = bst_st & CBIM_BST_EVENT_BITS;
    else if (ofs == CBIM_CHG_MASK_OFS)
      val = chg_mk;
    else if (ofs == CBIM_BST_MASK_OFS)
      val = bst_mk;
    else if (ofs == CBIM_ID_OFS)
      val = ident;
    return val;
  endfunction : read_reg

  assign rd_value = read_reg(ptr_reg, chg_status, bst_status, charger_event_mask_reg,
                             boost_event_mask_reg, id_value);

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_seen = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // Serial transfer engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= CBIM_IDLE;
      bit_cnt_reg <= CBIM_BIT_CNT_RESET;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_reg <= CBIM_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else if (start_seen)
    begin
      state_reg <= CBIM_ADDR;
      bit_cnt_reg <= CBIM_BIT_CNT_RESET;
      sda_oe_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state_reg == CBIM_RDATA_ACK)
      begin
        nack_reg <= sda_s;
      end
      else if (state_reg != CBIM_IDLE)
      begin
        shift_reg <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      case (state_reg)
        CBIM_ADDR:
        begin
          if (bit_cnt_reg == CBIM_BITS_PER_BYTE)
          begin
            if (shift_reg[7:1] == BUS_ADDR)
            begin
              rw_reg <= shift_reg[0];
              sda_oe_reg <= 1'b1;
              state_reg <= CBIM_ADDR_ACK;
            end
            else
            begin
              state_reg <= CBIM_IDLE;
            end
          end
        end
        CBIM_ADDR_ACK:
        begin
          bit_cnt_reg <= CBIM_BIT_CNT_RESET;
          if (rw_reg)
          begin
            tx_reg <= rd_value;
            sda_oe_reg <= ~rd_value[7];
            state_reg <= CBIM_RDATA;
          end
          else
          begin
            sda_oe_reg <= 1'b0;
            state_reg <= CBIM_PTR;
          end
        end
        CBIM_PTR:
        begin
          if (bit_cnt_reg == CBIM_BITS_PER_BYTE)
          begin
            ptr_reg <= shift_reg;
            sda_oe_reg <= 1'b1;
            state_reg <= CBIM_PTR_ACK;
          end
        end
        CBIM_PTR_ACK, CBIM_WDATA_ACK:
        begin
          sda_oe_reg <= 1'b0;
          bit_cnt_reg <= CBIM_BIT_CNT_RESET;
          state_reg <= CBIM_WDATA;
        end
        CBIM_WDATA:
        begin
          if (bit_cnt_reg == CBIM_BITS_PER_BYTE)
          begin
            ptr_reg <= ptr_reg + 8'h01;
            sda_oe_reg <= 1'b1;
            state_reg <= CBIM_WDATA_ACK;
          end
        end
        CBIM_RDATA:
        begin
          if (bit_cnt_reg == CBIM_BITS_PER_BYTE)
          begin
            ptr_reg <= ptr_reg + 8'h01;
            sda_oe_reg <= 1'b0;
            state_reg <= CBIM_RDATA_ACK;
          end
          else
          begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            sda_oe_reg <= ~tx_reg[6];
          end
        end
        CBIM_RDATA_ACK:
        begin
          bit_cnt_reg <= CBIM_BIT_CNT_RESET;
          if (nack_reg)
          begin
            state_reg <= CBIM_IDLE;
          end
          else
          begin
            tx_reg <= rd_value;
            sda_oe_reg <= ~rd_value[7];
            state_reg <= CBIM_RDATA;
          end
        end
        default:
        begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      charger_event_mask_reg <= CBIM_MASK_RESET;
      boost_event_mask_reg <= CBIM_MASK_RESET;
    end
    else if (scl_fall && state_reg == CBIM_WDATA && bit_cnt_reg == CBIM_BITS_PER_BYTE)
    begin
      if (ptr_reg == CBIM_CHG_MASK_OFS)
      begin
        charger_event_mask_reg <= shift_reg;
      end
      else if (ptr_reg == CBIM_BST_MASK_OFS)
      begin
        boost_event_mask_reg <= shift_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Masks gate only this request, never a protection path
  assign int_req_next = |(chg_status & ~charger_event_mask_reg)
    | |(bst_status & CBIM_BST_EVENT_BITS & ~boost_event_mask_reg);

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      int_req_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end
    else
    begin
      int_req_reg <= int_req_next;
      sda_out_reg <= 1'b0;
    end
  end

  assign int_req_out = int_req_reg;
  assign sda_oe_out = sda_oe_reg;
  assign sda_out = sda_out_reg;

endmodule : cbim_top

//--- verif/cbim_asserts.sv
// Checker for interrupt and data-line drive behaviour at the block pins
// Assumes binding onto cbim_top, bus phases of 10 clocks or more
`timescale 1ns/10ps
module cbim_asserts
  import cbim_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [7:0] charger_event_status_in,
  input wire logic [7:0] boost_event_status_in,
  input wire logic int_req_out
);
  // ----
  // Helpers
  // ----
  wire logic [15:0] st = {charger_event_status_in, boost_event_status_in};
  logic [15:0] st_prev_reg;
  logic [2:0] st_cnt_reg;
  logic [2:0] scl_cnt_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic used_reg;
  always_ff @(posedge ref_clk_in)
  begin
    st_prev_reg <= st;
    scl_prev_reg <= scl_in;
    sda_prev_reg <= sda_in;
    if (!rst_n_in || st != st_prev_reg)
      st_cnt_reg <= 3'h0;
    else if (st_cnt_reg != 3'h7)
      st_cnt_reg <= st_cnt_reg + 3'h1;
    if (!rst_n_in || scl_in != scl_prev_reg)
      scl_cnt_reg <= 3'h0;
    else if (scl_cnt_reg != 3'h7)
      scl_cnt_reg <= scl_cnt_reg + 3'h1;
    if (!rst_n_in)
      used_reg <= 1'b0;
    else if (scl_in && sda_prev_reg && !sda_in)
      used_reg <= 1'b1;
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_quiet;
    st_cnt_reg >= 3'h4 && st[15:8] == 8'h00 && st[7:3] == 5'h00 |-> !int_req_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("int without event");
  property p_chg;
    !used_reg && st_cnt_reg >= 3'h4 && |st[15:8] |-> int_req_out;
  endproperty
  a_chg: assert property (p_chg)
    else $error("charger event lost");
  property p_bst;
    !used_reg && st_cnt_reg >= 3'h4 && |st[7:3] |-> int_req_out;
  endproperty
  a_bst: assert property (p_bst)
    else $error("boost event lost");
  property p_hold;
    st_cnt_reg >= 3'h5 && scl_cnt_reg >= 3'h5 |-> $stable(int_req_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("int moved with no cause");
  property p_oe_low;
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_low: assert property (p_oe_low)
    else $error("data moved with clock high");
  property p_oe_len;
    $rose(sda_oe_out) |-> sda_oe_out [*4];
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("short bit");
  property p_od;
    sda_oe_out |-> sda_out == 1'b0;
  endproperty
  a_od: assert property (p_od)
    else $error("data line driven high");
  property p_idle;
    !used_reg |-> ##1 !sda_oe_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("drive with no transfer");
endmodule : cbim_asserts
bind cbim_top cbim_asserts i_chk (.*);

//--- verif/cbim_host.sv
// Two-wire bus host model
// Assumes a pull-up on the data line, wire level fed to sda_in
`timescale 1ns/10ps
module cbim_host
#(
  parameter logic [6:0] ADDR = 7'h3a
)
(
  input wire logic ref_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // ----
  // Bus phases
  // ----
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic hw;
    repeat (10) @(negedge ref_clk_in);
  endtask : hw
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge ref_clk_in);
    sda_low_out = !b;
    hw();
    scl_out = 1'b1;
    hw();
    r = sda_in;
    scl_out = 1'b0;
  endtask : bit_io
  task automatic start;
    hw();
    sda_low_out = 1'b0;
    hw();
    scl_out = 1'b1;
    hw();
    sda_low_out = 1'b1;
    hw();
    scl_out = 1'b0;
  endtask : start
  task automatic stop;
    hw();
    sda_low_out = 1'b1;
    hw();
    scl_out = 1'b1;
    hw();
    sda_low_out = 1'b0;
    hw();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, r);
    ack = !r;
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                    output logic ok);
    logic [7:0] q;
    logic [3:0] k;
    start();
    xfer({a, 1'b0}, 1'b1, q, k[0]);
    xfer(p, 1'b1, q, k[1]);
    xfer(d[15:8], 1'b1, q, k[2]);
    xfer(d[7:0], 1'b1, q, k[3]);
    stop();
    ok = &k;
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic [7:0] q;
    logic k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, k);
    xfer(p, 1'b1, q, k);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q, k);
    xfer(8'hff, 1'b0, d[15:8], k);
    xfer(8'hff, 1'b1, d[7:0], k);
    stop();
  endtask : rd
endmodule : cbim_host

//--- verif/test_cbim_top.sv
// Self-checking bench for the event mask and identification block
// Assumes the host model and checker are compiled beforehand
`timescale 1ns/10ps
module test_cbim_top;
  import cbim_pkg::*;
  localparam logic [1:0] MK = 2'h1; // Arbitrary value
  localparam logic [2:0] PT = 3'h3; // Arbitrary value
  localparam logic [2:0] VR = 3'h2; // Arbitrary value
  // ----
  // Harness
  // ----
  logic ref_clk_in;
  logic rst_n_in;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic int_req;
  logic ok;
  logic [7:0] chg;
  logic [7:0] bst;
  logic [15:0] rdat;
  wire sda;
  int mismatches;
  int total_checks;
  int cyc;
  logic [35:0] rows [9] = '{36'h000001001, 36'h010001000, 36'h800080000, 36'h7f0080001,
    36'hff8ff0070, 36'h008000081, 36'h0f0000081, 36'hff7000f81, 36'h008000800};
  assign sda = !(sda_low | sda_oe);
  cbim_top #(.ID_MAKER(MK), .ID_PART(PT), .ID_VERSION(VR)) i_dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .charger_event_status_in(chg),
    .boost_event_status_in(bst), .int_req_out(int_req));
  cbim_host i_host (.ref_clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = !ref_clk_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  // ----
  // Sequence
  // ----
  initial
  begin
    rst_n_in = 1'b0;
    chg = 8'h00;
    bst = 8'h00;
    repeat (5) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    foreach (rows[i])
    begin
      i_host.wr(7'h3a, 8'h0c, rows[i][35:20], ok);
      chk({15'h0, ok}, 16'h1);
      i_host.rd(8'h0c, rdat);
      chk(rdat, rows[i][35:20]);
      chg = rows[i][19:12];
      bst = rows[i][11:4];
      repeat (6) @(negedge ref_clk_in);
      chk({15'h0, int_req}, {15'h0, rows[i][0]});
    end
    i_host.wr(7'h3b, 8'h0c, 16'hffff, ok);
    chk({15'h0, ok}, 16'h0);
    i_host.rd(8'h0c, rdat);
    chk(rdat, 16'h0080);
    i_host.wr(7'h3a, 8'h0e, 16'h00ff, ok);
    i_host.rd(8'h0e, rdat);
    chk(rdat, {MK, PT, VR, 8'h00});
    chg = 8'h5a;
    bst = 8'hcf;
    i_host.rd(8'h09, rdat);
    chk(rdat, 16'h5ac8);
    i_host.wr(7'h3a, 8'h0c, 16'hffff, ok);
    repeat (6) @(negedge ref_clk_in);
    chk({15'h0, int_req}, 16'h0);
    rst_n_in = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    chk({15'h0, int_req}, 16'h1);
    i_host.rd(8'h0c, rdat);
    chk(rdat, 16'h0000);
    print_verdict();
  end
endmodule : test_cbim_top
